// ### lpf_consts.svh
// named constants for the decimation and low-pass chain
`ifndef LPF_CONSTS_SVH
`define LPF_CONSTS_SVH

`define SYS_CLK_PERIOD_NS 20
`define SD_PERIOD_NS      1000
`define SD_DIV            (`SD_PERIOD_NS / `SYS_CLK_PERIOD_NS)
`define DEC_RATIO         16
`define SINC_MID          14'h0800
`define COEF_FRAC         28
`define DATA_IN_SHIFT     16
`define OUT_LSB           12

// group delays in oscillator periods, for reference by the consumer
`define GDELAY_180        4608
`define GDELAY_400        3392
`define GDELAY_800        1728

`define SEL_180           2'h0
`define SEL_400           2'h1
`define SEL_800           2'h2

// coefficients in Q3.28; the leading denominator term is always one
`define A0_180  32'sh00023003
`define N11_180 32'sh04000000
`define N12_180 32'sh07FFFFFC
`define N13_180 32'sh04000000
`define D12_180 (-32'sh1F5B80C0)
`define D13_180 32'sh0F5DB0C0
`define UNITY   32'sh10000000

`define A0_400  32'sh000CD852
`define N11_400 32'sh000417F8
`define N12_400 32'sh0008300C
`define N13_400 32'sh000417F4
`define D12_400 (-32'sh1E477C40)
`define D13_400 32'sh0E545490
`define N21_400 32'sh040004FC
`define N22_400 32'sh07FFF15C
`define N23_400 32'sh040009A4
`define D22_400 (-32'sh1EB48800)
`define D23_400 32'sh0EC4E7F0

`define A0_800  32'sh0030C25D
`define N11_800 32'sh000FBC2C
`define N12_800 32'sh001F7884
`define N13_800 32'sh000FBC24
`define D12_800 (-32'sh1CA3DBE0)
`define D13_800 32'sh0CD49E40
`define N21_800 32'sh040001F4
`define N22_800 32'sh07FFF9E0
`define N23_800 32'sh04000430
`define D22_800 (-32'sh1D63BC40)
`define D23_800 32'sh0DA2AD10

`endif

// ### lpf_pkg.sv
// types shared by the decimation and low-pass chain
package lpf_pkg;
    typedef logic signed [31:0] coef_t;
    typedef logic signed [39:0] acc_t;

    typedef struct packed {
        coef_t n1;
        coef_t n2;
        coef_t n3;
        coef_t d2;
        coef_t d3;
    } biquad_coef_t;

    typedef struct packed {
        coef_t        a0;
        biquad_coef_t s1;
        biquad_coef_t s2;
    } lp_coef_t;

    typedef struct packed {
        logic               valid;
        logic signed [25:0] data;
    } lp_out_t;

    typedef enum logic [2:0] {LP_IDLE, LP_GAIN, LP_SEC1, LP_SEC2, LP_HOLD} lp_state_t;
endpackage

// ### sample_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output wire logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output wire logic             out_valid,
    input  wire logic             out_ready,
    output wire logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;

    // depth must be a power of two so the pointers wrap by themselves
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // storage is written without reset; only pointers and fill count need a defined value
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill count; a push and a pop together leave the count alone
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= push ? wr_q + 1'b1 : wr_q;
            rd_q  <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### accel_decimation_lowpass_chain.sv
// sinc3 decimator and selectable two-section iir low-pass for the acceleration path
`timescale 1ns/1ps
`include "lpf_consts.svh"

module accel_decimation_lowpass_chain
    import lpf_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               sd_bit,
    output wire logic               sd_tick,
    input  wire logic [1:0]         lowpass_select,
    output wire logic signed [25:0] lp_data,
    output wire logic               lp_valid,
    input  wire logic               lp_ready,
    output wire logic               sinc_overrun
);
    // every check runs on the system clock and sleeps through reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // coefficient set lookup; an unused code falls back to 180 Hz
    function automatic lp_coef_t coef_set(input logic [1:0] sel);
        lp_coef_t c;
        c = '0;
        case (sel)
            `SEL_400: begin
                c.a0 = `A0_400;
                c.s1 = '{`N11_400, `N12_400, `N13_400, `D12_400, `D13_400};
                c.s2 = '{`N21_400, `N22_400, `N23_400, `D22_400, `D23_400};
            end
            `SEL_800: begin
                c.a0 = `A0_800;
                c.s1 = '{`N11_800, `N12_800, `N13_800, `D12_800, `D13_800};
                c.s2 = '{`N21_800, `N22_800, `N23_800, `D22_800, `D23_800};
            end
            default: begin
                c.a0 = `A0_180;
                c.s1 = '{`N11_180, `N12_180, `N13_180, `D12_180, `D13_180};
                c.s2 = '{n1: `UNITY, default: '0};
            end
        endcase
        return c;
    endfunction

    // direct form one section, wide accumulator so no term can overflow
    function automatic acc_t biquad(input acc_t din, input acc_t x1, input acc_t x2,
                                    input acc_t y1, input acc_t y2, input biquad_coef_t c);
        logic signed [75:0] acc;
        acc = din * c.n1 + x1 * c.n2 + x2 * c.n3 - y1 * c.d2 - y2 * c.d3;
        return acc[`COEF_FRAC+39:`COEF_FRAC];
    endfunction

    // 1 MHz bit tick derived from the system clock
    logic [5:0] div_q;
    logic       tick_q;
    wire        div_wrap = (div_q == 6'(`SD_DIV - 1));
    assign sd_tick = tick_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_wrap ? '0 : div_q + 1'b1;
            tick_q <= div_wrap;
        end
    end

    // sinc3: integrators at bit rate, combs at the decimated rate
    logic [12:0]        int1_q, int2_q, int3_q;
    logic [12:0]        dly1_q, dly2_q, dly3_q;
    logic [3:0]         phase_q;
    logic signed [13:0] sinc_q;
    logic               sinc_valid_q;
    logic               ovr_q;
    wire                dec_now = tick_q && (phase_q == 4'(`DEC_RATIO - 1));
    wire [12:0]         comb1 = int3_q - dly1_q;
    wire [12:0]         comb2 = comb1 - dly2_q;
    wire [12:0]         comb3 = comb2 - dly3_q;

    // modular wrap in the integrators is harmless, the combs undo it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int1_q       <= '0;
            int2_q       <= '0;
            int3_q       <= '0;
            dly1_q       <= '0;
            dly2_q       <= '0;
            dly3_q       <= '0;
            phase_q      <= '0;
            sinc_q       <= '0;
            sinc_valid_q <= 1'b0;
        end else begin
            sinc_valid_q <= dec_now;
            if (tick_q) begin
                int1_q  <= int1_q + {12'h000, sd_bit};
                int2_q  <= int2_q + int1_q;
                int3_q  <= int3_q + int2_q;
                phase_q <= phase_q + 1'b1;
            end
            if (dec_now) begin
                dly1_q <= int3_q;
                dly2_q <= comb1;
                dly3_q <= comb2;
                sinc_q <= 14'({1'b0, comb3} - `SINC_MID);
            end
        end
    end

    // fifo between decimator and filter; a full fifo drops and flags the sample
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [13:0] fifo_out_data;
    lp_state_t  state_q;
    wire        take = fifo_out_valid && (state_q == LP_IDLE);

    sample_fifo #(
        .WIDTH (14),
        .DEPTH (16)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (sinc_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (sinc_q),
        .out_valid (fifo_out_valid),
        .out_ready (state_q == LP_IDLE),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ovr_q <= 1'b0;
        end else begin
            ovr_q <= ovr_q | (sinc_valid_q & ~fifo_in_ready);
        end
    end
    assign sinc_overrun = ovr_q;

    // filter datapath selection
    logic [1:0]   sel_q;
    acc_t         work_q;
    acc_t         hx1_q [2];
    acc_t         hx2_q [2];
    acc_t         hy1_q [2];
    acc_t         hy2_q [2];
    lp_out_t      lp_q;
    lp_coef_t     coef;
    biquad_coef_t sec_c;
    acc_t         sec_out;
    acc_t         gain_out;
    logic         sec_idx;
    assign coef     = coef_set(sel_q);
    assign sec_idx  = (state_q == LP_SEC2);
    assign sec_c    = sec_idx ? coef.s2 : coef.s1;
    assign sec_out  = biquad(work_q, hx1_q[sec_idx], hx2_q[sec_idx], hy1_q[sec_idx], hy2_q[sec_idx], sec_c);
    assign gain_out = biquad(work_q, '0, '0, '0, '0, '{n1: coef.a0, default: '0});
    assign lp_data  = lp_q.data;
    assign lp_valid = lp_q.valid;

    // one pass per sample; a change of set flushes history to avoid a mixed-set transient
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= LP_IDLE;
            sel_q   <= `SEL_180;
            work_q  <= '0;
            lp_q    <= '0;
            for (int i = 0; i < 2; i++) begin
                hx1_q[i] <= '0;
                hx2_q[i] <= '0;
                hy1_q[i] <= '0;
                hy2_q[i] <= '0;
            end
        end else begin
            case (state_q)
                LP_IDLE: begin
                    if (take) begin
                        work_q  <= acc_t'($signed(fifo_out_data)) <<< `DATA_IN_SHIFT;
                        sel_q   <= lowpass_select;
                        state_q <= LP_GAIN;
                        if (lowpass_select != sel_q) begin
                            for (int i = 0; i < 2; i++) begin
                                hx1_q[i] <= '0;
                                hx2_q[i] <= '0;
                                hy1_q[i] <= '0;
                                hy2_q[i] <= '0;
                            end
                        end
                    end
                end
                LP_GAIN: begin
                    work_q  <= gain_out;
                    state_q <= LP_SEC1;
                end
                LP_SEC1, LP_SEC2: begin
                    hx2_q[sec_idx] <= hx1_q[sec_idx];
                    hx1_q[sec_idx] <= work_q;
                    hy2_q[sec_idx] <= hy1_q[sec_idx];
                    hy1_q[sec_idx] <= sec_out;
                    work_q         <= sec_out;
                    if (sec_idx) begin
                        lp_q.data  <= sec_out[`OUT_LSB+25:`OUT_LSB];
                        lp_q.valid <= 1'b1;
                        state_q    <= LP_HOLD;
                    end else begin
                        state_q <= LP_SEC2;
                    end
                end
                LP_HOLD: begin
                    if (lp_ready) begin
                        lp_q.valid <= 1'b0;
                        state_q    <= LP_IDLE;
                    end
                end
                default: begin
                    state_q <= LP_IDLE;
                end
            endcase
        end
    end

    // helper: bit ticks seen between decimated samples
    logic [4:0] ticks_since_q;
    logic       dec_seen_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ticks_since_q <= '0;
            dec_seen_q    <= 1'b0;
        end else if (sinc_valid_q) begin
            ticks_since_q <= '0;
            dec_seen_q    <= 1'b1;
        end else if (tick_q) begin
            ticks_since_q <= ticks_since_q + 1'b1;
        end
    end

    chk_tick_period: assert property (tick_q |-> ##50 tick_q)
        else $error("bit tick period is not 50 cycles");
    chk_tick_gap: assert property (tick_q |=> (!tick_q) [*8])
        else $error("bit tick repeated too soon");
    chk_dec_ratio: assert property (sinc_valid_q && dec_seen_q |-> ticks_since_q == 5'(`DEC_RATIO))
        else $error("decimation ratio is not sixteen");
    chk_sinc_range: assert property (sinc_valid_q |-> sinc_q >= -14'sd2048 && sinc_q <= 14'sd2048)
        else $error("sinc sample out of range");
    chk_pass_order: assert property (take |=> state_q == LP_GAIN ##1 state_q == LP_SEC1
                                              ##1 state_q == LP_SEC2 ##1 lp_valid)
        else $error("filter pass order broken");
    chk_sel_latch: assert property (take |=> sel_q == $past(lowpass_select))
        else $error("filter select not latched");
    chk_gain_stage: assert property (state_q == LP_GAIN && sel_q == `SEL_180
                                     |-> gain_out == biquad(work_q, '0, '0, '0, '0, '{n1: `A0_180, default: '0}))
        else $error("gain stage uses wrong factor");
    chk_pass_180: assert property (state_q == LP_SEC2 && sel_q == `SEL_180 |-> sec_out == work_q)
        else $error("180 Hz second section not transparent");
    chk_coef_400: assert property (state_q == LP_SEC1 && sel_q == `SEL_400
                                   |-> sec_c.d2 == `D12_400 && coef.a0 == `A0_400)
        else $error("400 Hz set not applied");
    chk_coef_800: assert property (state_q == LP_SEC2 && sel_q == `SEL_800
                                   |-> sec_c.d2 == `D22_800 && coef.a0 == `A0_800)
        else $error("800 Hz set not applied");
    chk_out_hold: assert property (lp_valid && !lp_ready |=> lp_valid && $stable(lp_data))
        else $error("output dropped before accepted");

    cov_sample: cover property (sinc_valid_q && fifo_in_ready);
    cov_overrun: cover property (sinc_valid_q && !fifo_in_ready);
    cov_out_400: cover property (lp_valid && lp_ready && sel_q == `SEL_400);
    cov_out_800: cover property (lp_valid && lp_ready && sel_q == `SEL_800);
endmodule

// ### sd_mod_model.sv
// sigma-delta modulator model feeding the bit input of the chain
`timescale 1ns/1ps
module sd_mod_model (
    input  wire logic       sys_clk,
    input  wire logic       sd_tick,
    input  wire logic [4:0] level,
    output logic            sd_bit
);
    int acc = 0;

    initial sd_bit = 1'b0;

    // first-order loop: for level up to 16, any 16 bits in a row hold exactly level ones
    always @(negedge sys_clk) begin
        if (sd_tick === 1'b1) begin
            acc = acc + level;
            sd_bit <= (acc >= 16);
            if (acc >= 16) begin
                acc = acc - 16;
            end
        end else begin
            sd_bit <= ~sd_bit; // bit is only valid at the strobe edge
        end
    end
endmodule

// ### accel_decimation_lowpass_chain_tb.sv
// self-checking bench for the decimation and low-pass chain
`timescale 1ns/1ps
module accel_decimation_lowpass_chain_tb;
    typedef struct {logic [1:0] sel; logic [4:0] lvl; int smp; int cs;} row_t;

    logic               sys_clk        = 1'b0;
    logic               rst_n          = 1'b0;
    logic [1:0]         lowpass_select = 2'h0;
    logic               lp_ready       = 1'b1;
    logic [4:0]         level          = 5'h08;
    logic               sd_bit;
    logic               sd_tick;
    logic               lp_valid;
    logic               sinc_overrun;
    logic signed [25:0] lp_data;
    int                 mismatches     = 0;
    int                 checks_done    = 0;
    real                st [8];
    real a0 [3] = '{0.000534069200512, 0.003135988372378, 0.011904109735042};
    real nc [3][6] = '{'{0.25, 0.499999985098839, 0.25, 1.0, 0.0, 0.0},
        '{0.000999420881271, 0.001998946070671, 0.000999405980110,
          0.250004753470421, 0.499986037611961, 0.250009194016457},
        '{0.003841564059258, 0.007683292031288, 0.003841534256935,
          0.250001862645149, 0.499994158744812, 0.250003993511200}};
    real dc [3][4] = '{'{-1.959839582443237, 0.960373640060425, 0.0, 0.0},
        '{-1.892452478408814, 0.89558845758438, -1.919075012207031, 0.923072755336761},
        '{-1.790004611015320, 0.801908731460571, -1.836849451065064, 0.852215826511383}};
    // row: select code, modulator density, expected sinc sample, coefficient set it should use
    // code 3 second so every row really changes the select and still lands on the 180 Hz set
    row_t rows [4] = '{'{2'h1, 5'h10, 2048, 1}, '{2'h3, 5'h00, -2048, 0},
                       '{2'h2, 5'h08, 0, 2}, '{2'h0, 5'h0C, 1024, 0}};

    always #10 sys_clk = ~sys_clk;

    accel_decimation_lowpass_chain u_dut (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .sd_bit         (sd_bit),
        .sd_tick        (sd_tick),
        .lowpass_select (lowpass_select),
        .lp_data        (lp_data),
        .lp_valid       (lp_valid),
        .lp_ready       (lp_ready),
        .sinc_overrun   (sinc_overrun)
    );

    sd_mod_model u_mod (
        .sys_clk (sys_clk),
        .sd_tick (sd_tick),
        .level   (level),
        .sd_bit  (sd_bit)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0b seen %0b", what, exp, got);
        end
    endtask

    task automatic cmp_near(input string what, input int exp, input logic signed [25:0] got, input int tol);
        checks_done++;
        if ((^got === 1'bx) || (got - exp > tol) || (exp - got > tol)) begin
            mismatches++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask

    // floating reference: gain, then two direct-form sections
    task automatic ref_step(input real x, input int s, output real y);
        real v;
        v = a0[s] * x;
        for (int k = 0; k < 2; k++) begin
            y = nc[s][3*k] * v + nc[s][3*k+1] * st[4*k] + nc[s][3*k+2] * st[4*k+1]
                - dc[s][2*k] * st[4*k+2] - dc[s][2*k+1] * st[4*k+3];
            st[4*k+1] = st[4*k];
            st[4*k] = v;
            st[4*k+3] = st[4*k+2];
            st[4*k+2] = y;
            v = y;
        end
    endtask

    // bounded wait, sampled mid-cycle so edge updates have landed
    task automatic wait_valid();
        int n;
        n = 0;
        while (lp_valid !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        cmp_bit("lp_valid", 1'b1, lp_valid);
    endtask

    task automatic get_result(output logic signed [25:0] d);
        wait_valid();
        d = lp_data;
        @(negedge sys_clk);
    endtask

    task automatic check_quiet();
        cmp_bit("sd_tick", 1'b0, sd_tick);
        cmp_bit("lp_valid", 1'b0, lp_valid);
        cmp_bit("sinc_overrun", 1'b0, sinc_overrun);
        cmp_near("lp_data", 0, lp_data, 0);
    endtask

    // watchdog: the tests need about 70k cycles, give up after 100k
    initial begin
        #(100000 * 20);
        mismatches++;
        close_out();
    end

    initial begin
        logic signed [25:0] d;
        real                y;
        int                 n;
        repeat (2) @(negedge sys_clk);
        check_quiet();
        rst_n = 1'b1;
        n = 0;
        while (sd_tick !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (sd_tick !== 1'b1 && n < 100);
        cmp_near("tick period", 50, 26'(n), 0);
        // each row: settle the sinc, switch the set, follow the step
        for (int r = 0; r < 4; r++) begin
            level = rows[r].lvl;
            repeat (5) get_result(d);
            lowpass_select = rows[r].sel;
            st = '{default: 0.0};
            for (int k = 0; k < 12; k++) begin
                ref_step(real'(rows[r].smp), rows[r].cs, y);
                get_result(d);
                cmp_near("lp_data", $rtoi(y * 16.0), d, 16);
            end
        end
        // stall the consumer: sixteen samples fit, the next ones drop
        lp_ready = 1'b0;
        wait_valid();
        d = lp_data;
        repeat (15 * 800) @(negedge sys_clk);
        cmp_bit("sinc_overrun", 1'b0, sinc_overrun);
        cmp_bit("lp_valid", 1'b1, lp_valid);
        cmp_near("held lp_data", d, lp_data, 0);
        repeat (3 * 800) @(negedge sys_clk);
        cmp_bit("sinc_overrun", 1'b1, sinc_overrun);
        lp_ready = 1'b1;
        n = 0;
        repeat (200) begin
            if (lp_valid === 1'b1) begin
                n++;
            end
            @(negedge sys_clk);
        end
        cmp_bit("drained count", 1'b1, n == 17 || n == 18);
        cmp_bit("sinc_overrun", 1'b1, sinc_overrun);
        // a second reset in mid-run clears the sticky flag
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_quiet();
        rst_n = 1'b1;
        // the first two edges after release still show idle outputs
        repeat (2) @(negedge sys_clk);
        check_quiet();
        close_out();
    end
endmodule
